// [logic/core_timer_pkg.sv]
// Constants, field layouts and carrier types of the core timer block.
// Assumes a single CPU clock domain and a plain strobe register port.
package core_timer_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int TIMER_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam int PRESCALE_W = 10;
    localparam int CTRL_W = 11;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
    localparam logic [ADDR_W-1:0] TIMER_OFFSET = 8'h02;
    localparam logic [TIMER_W-1:0] TIMER_RESET = 16'h0000;
    localparam logic [TIMER_W-1:0] TIMER_MAX = 16'hFFFF;
    localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

    // ------------------------------------------------------------
    // Mode and input select codes
    // ------------------------------------------------------------
    localparam logic [2:0] MODE_TIMER = 3'h0;
    localparam logic [2:0] MODE_COUNTER = 3'h1;
    localparam logic [2:0] MODE_GATED_LOW = 3'h2;
    localparam logic [2:0] MODE_GATED_HIGH = 3'h3;
    localparam logic [2:0] MODE_ENCODER = 3'h6;

    // Prescale factor 8 needs three always-set mask bits
    localparam logic [PRESCALE_W-1:0] PRESCALE_BASE_MASK = 10'h007;
    localparam logic [PRESCALE_W-1:0] PRESCALE_RESET = 10'h000;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic toggle_latch;
        logic out_en;
        logic ext_dir_en;
        logic dir_sel;
        logic run_bit;
        logic [2:0] mode_field;
        logic [2:0] input_select_field;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = 11'h000;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic count_level;
        logic count_rise;
        logic count_fall;
        logic dir_level;
        logic dir_rise;
        logic dir_fall;
    } pin_sample_t;

    typedef struct packed {
        ctrl_t ctrl;
        logic [TIMER_W-1:0] timer;
        logic [PRESCALE_W-1:0] prescale;
        logic [DATA_W-1:0] rdata;
        logic alt_out;
        logic count_down;
        logic count_pulse;
    } timer_state_t;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Mask of low prescaler bits: factor 8 * 2**sel, minus one
    function automatic logic [PRESCALE_W-1:0] prescale_mask(input logic [2:0] sel);
        logic [PRESCALE_W-1:0] m;
        m = PRESCALE_BASE_MASK;
        for (int i = 0; i < 7; i++) begin
            if (i < int'(sel)) begin
                m = {m[PRESCALE_W-2:0], 1'b1};
            end
        end
        return m;
    endfunction : prescale_mask

    // Select code bit 0 takes the first event, bit 1 the second, 1xx none
    function automatic logic edge_hit(input logic [2:0] sel, input logic ev_a,
                                      input logic ev_b);
        return !sel[2] && ((sel[0] && ev_a) || (sel[1] && ev_b));
    endfunction : edge_hit

endpackage : core_timer_pkg

// [logic/input_edge_sampler.sv]
// Two-flop synchroniser with edge detection for asynchronous pins.
// Assumes the pins are held stable for several clock cycles per level.
`timescale 1ns/1ns
module input_edge_sampler #(
    parameter int WIDTH = 2
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] raw_in,
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out,
    output logic [WIDTH-1:0] fall_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] prev;
    } sampler_state_t;

    sampler_state_t state_reg;
    sampler_state_t state_next;

    // The first stage feeds only the second stage
    always_comb begin
        state_next = state_reg;
        state_next.meta = raw_in;
        state_next.stable = state_reg.meta;
        state_next.prev = state_reg.stable;
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_out = state_reg.stable;
    assign rise_out = state_reg.stable & ~state_reg.prev;
    assign fall_out = ~state_reg.stable & state_reg.prev;

endmodule : input_edge_sampler

// [logic/core_timer.sv]
// Core 16-bit timer: timer, gated timer, counter and encoder modes.
// Assumes the CPU clock on clock_in and pins that come in asynchronously.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
module core_timer (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [core_timer_pkg::ADDR_W-1:0] addr_in,
    input wire logic [core_timer_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic count_gate_in,
    input wire logic direction_in,
    output logic [core_timer_pkg::DATA_W-1:0] rdata_out,
    output logic [core_timer_pkg::TIMER_W-1:0] timer_value_out,
    output logic toggle_latch_out,
    output logic alt_out_out,
    output logic count_down_out,
    output logic count_pulse_out
);
    import core_timer_pkg::*;

    // Every output is a field of state_reg, so no port is reached
    // through combinational logic; software sees a count one cycle
    // after the event that caused it.

    // ------------------------------------------------------------
    // Pin sampling
    // ------------------------------------------------------------
    // Both pins are asynchronous. Three cycles pass from a pin change
    // to the count it causes, well inside the eight-cycle hold rule.
    // Bit 0 carries the count or gate pin, bit 1 the direction pin.
    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    pin_sample_t pins;

    input_edge_sampler #(
        .WIDTH(2)
    ) u_sampler (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .raw_in({direction_in, count_gate_in}),
        .level_out(pin_level),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    always_comb begin
        pins.count_level = pin_level[0];
        pins.count_rise = pin_rise[0];
        pins.count_fall = pin_fall[0];
        pins.dir_level = pin_level[1];
        pins.dir_rise = pin_rise[1];
        pins.dir_fall = pin_fall[1];
    end

    // ------------------------------------------------------------
    // Bus request
    // ------------------------------------------------------------
    bus_req_t req;

    always_comb begin
        req.addr = addr_in;
        req.wdata = wdata_in;
        req.wr = wr_in;
        req.rd = rd_in;
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    timer_state_t state_reg;
    timer_state_t state_next;

    // Per-cycle decisions, all taken from the registered control fields
    // so that a control write acts from the following cycle on.
    logic tick;
    logic gate_active;
    logic count_event;
    logic down;
    logic wrap;
    logic ctrl_write;
    logic timer_write;
    ctrl_t ctrl;
    ctrl_t ctrl_wr;

    always_comb begin
        ctrl = state_reg.ctrl;
        ctrl_wr = ctrl_t'(req.wdata[CTRL_W-1:0]);
        ctrl_write = req.wr && (req.addr == CTRL_OFFSET);
        timer_write = req.wr && (req.addr == TIMER_OFFSET);

        tick = (state_reg.prescale & prescale_mask(ctrl.input_select_field))
               == prescale_mask(ctrl.input_select_field);

        // gate level per mode bit
        // The synchronised level is used, so a gate pulse shorter than one
        // cycle may be missed; the source hold rule excludes it.
        gate_active = (pins.count_level == ctrl.mode_field[0]);

        if (ctrl.ext_dir_en) begin
            down = pins.dir_level ^ ctrl.dir_sel;
        end else begin
            down = ctrl.dir_sel;
        end

        count_event = 1'b0;
        case (ctrl.mode_field)
            MODE_TIMER: begin
                count_event = ctrl.run_bit && tick;
            end
            MODE_GATED_LOW, MODE_GATED_HIGH: begin
                count_event = ctrl.run_bit && tick && gate_active;
            end
            MODE_COUNTER: begin
                count_event = ctrl.run_bit && edge_hit(ctrl.input_select_field,
                              pins.count_rise, pins.count_fall);
            end
            MODE_ENCODER: begin
                count_event = ctrl.run_bit && edge_hit(ctrl.input_select_field,
                              pins.count_rise || pins.count_fall,
                              pins.dir_rise || pins.dir_fall);
                // count-input edge direction
                // Edges on both phases at once are outside the legal
                // gray walk; the count-input edge then sets direction.
                if (pins.count_rise) begin
                    down = pins.dir_level;
                end else if (pins.count_fall) begin
                    down = !pins.dir_level;
                end else if (pins.dir_rise) begin
                    down = !pins.count_level;
                end else begin
                    down = pins.count_level;
                end
            end
            // Reserved modes hold the timer
            default: begin
                count_event = 1'b0;
            end
        endcase

        wrap = count_event && (down ? (state_reg.timer == TIMER_RESET)
                                    : (state_reg.timer == TIMER_MAX));
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;

        // Free-running prescaler; its low bits set the tick phase.
        // It is not cleared on start or on a select change, so the
        // first tick after start may come up to one period early:
        // cheaper than a restart path, and invisible at steady rate.
        state_next.prescale = state_reg.prescale + 1'b1;

        state_next.count_pulse = count_event;
        if (count_event) begin
            state_next.count_down = down;
        end

        if (count_event) begin
            if (down) begin
                state_next.timer = state_reg.timer - 1'b1;
            end else begin
                state_next.timer = state_reg.timer + 1'b1;
            end
        end

        if (timer_write) begin
            state_next.timer = req.wdata[TIMER_W-1:0];
        end

        // wrap toggles latch
        // A wrap still toggles when a timer write lands in the same
        // cycle, since the count that wrapped did happen.
        if (wrap) begin
            state_next.ctrl.toggle_latch = !ctrl.toggle_latch;
        end

        // A control write replaces all fields, latch included
        if (ctrl_write) begin
            state_next.ctrl = ctrl_wr;
        end

        // gate edges feed no interrupt; the block has no request line
        state_next.alt_out = state_next.ctrl.out_en && state_next.ctrl.toggle_latch;

        // Read data stand for one cycle only
        state_next.rdata = READ_IDLE;
        if (req.rd) begin
            case (req.addr)
                CTRL_OFFSET: begin
                    state_next.rdata = DATA_W'(ctrl);
                end
                TIMER_OFFSET: begin
                    state_next.rdata = state_reg.timer;
                end
                default: begin
                    state_next.rdata = READ_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Reset leaves timer mode selected but stopped, so the false edge
    // the sampler may show just after reset counts only if the first two edges after reset load a run in counter or encoder mode.
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state_reg.ctrl <= CTRL_RESET;
            state_reg.timer <= TIMER_RESET;
            state_reg.prescale <= PRESCALE_RESET;
            state_reg.rdata <= READ_IDLE;
            state_reg.alt_out <= 1'b0;
            state_reg.count_down <= 1'b0;
            state_reg.count_pulse <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Register port: idle zero except in the cycle after a read
    assign rdata_out = state_reg.rdata;

    // Timer and toggle latch, as last registered
    assign timer_value_out = state_reg.timer;
    assign toggle_latch_out = state_reg.ctrl.toggle_latch;

    // Alternate output is the latch qualified by its enable
    assign alt_out_out = state_reg.alt_out;

    // Direction holds from the last counted event; pulse is one cycle
    assign count_down_out = state_reg.count_down;
    assign count_pulse_out = state_reg.count_pulse;

endmodule : core_timer

// [verif/core_timer_assertions.sv]
// Port-level assertions for the core timer.
// Assumes a bind onto core_timer; sees its ports only.
`timescale 1ns/1ns
module core_timer_checker (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [core_timer_pkg::ADDR_W-1:0] addr_in,
    input wire logic [core_timer_pkg::DATA_W-1:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic count_gate_in,
    input wire logic direction_in,
    input wire logic [core_timer_pkg::DATA_W-1:0] rdata_out,
    input wire logic [core_timer_pkg::TIMER_W-1:0] timer_value_out,
    input wire logic toggle_latch_out,
    input wire logic count_down_out,
    input wire logic count_pulse_out
);
    import core_timer_pkg::*;
    ctrl_t sh_reg;
    ctrl_t sh_next;
    logic wt, wc, run, t8, cr, ea;
    logic [2:0] md, sl;
    assign wt = wr_in && addr_in == TIMER_OFFSET;
    assign wc = wr_in && addr_in == CTRL_OFFSET;
    // Control shadow rebuilt from bus writes, since the checker sees ports only
    always_comb begin
        sh_next = sh_reg;
        if (wc) begin
            sh_next = ctrl_t'(wdata_in[CTRL_W-1:0]);
        end
    end
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            sh_reg <= CTRL_RESET;
        end else begin
            sh_reg <= sh_next;
        end
    end
    assign md = sh_reg.mode_field;
    assign sl = sh_reg.input_select_field;
    assign run = sh_reg.run_bit;
    assign t8 = run && md == MODE_TIMER && sl == 3'h0;
    assign cr = run && md == MODE_COUNTER && sl == 3'h1;
    assign ea = run && md == MODE_ENCODER && !sl[2] && sl[0];
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    chk_read_idle: assert property (!$past(rd_in) |-> rdata_out == READ_IDLE)
        else $error("read data not idle");
    chk_timer_step: assert property (count_pulse_out && !$past(wt) |->
        timer_value_out == 16'($past(timer_value_out) + (count_down_out ? TIMER_MAX : 16'h0001)))
        else $error("timer step wrong");
    chk_timer_hold: assert property (!count_pulse_out && !$past(wt) |-> $stable(timer_value_out))
        else $error("timer moved without a count");
    chk_write_wins: assert property (wt |=> timer_value_out == $past(wdata_in))
        else $error("timer write lost");
    chk_wrap_toggle: assert property (count_pulse_out && !$past(wt) && !$past(wc)
        && timer_value_out == (count_down_out ? TIMER_MAX : TIMER_RESET)
        |-> toggle_latch_out != $past(toggle_latch_out)) else $error("latch not toggled");
    chk_run_stop: assert property (!run && !$past(run) |-> !count_pulse_out)
        else $error("count while stopped");
    chk_prescale_gap: assert property (count_pulse_out && t8 ##1 (t8 && !wt)[*7]
        |=> count_pulse_out) else $error("prescale period wrong");
    chk_cnt_rise: assert property (cr && $rose(count_gate_in)
        |-> ##[3:4] count_pulse_out) else $error("rising edge not counted");
    chk_enc_dir: assert property (ea && $rose(count_gate_in) && direction_in
        |-> ##[3:4] (count_pulse_out && count_down_out)) else $error("encoder direction wrong");
endmodule : core_timer_checker

bind core_timer core_timer_checker chk (
    .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .count_gate_in(count_gate_in),
    .direction_in(direction_in), .rdata_out(rdata_out), .timer_value_out(timer_value_out),
    .toggle_latch_out(toggle_latch_out), .count_down_out(count_down_out),
    .count_pulse_out(count_pulse_out)
);

// [verif/pin_source.sv]
// Behavioural gate, count and encoder source for the two pins.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ns
module pin_source (
    input wire logic clock_in,
    output logic phase_a_out,
    output logic phase_b_out
);
    logic [1:0] pos_reg;
    // Pins are only ever driven into the block
    initial begin
        phase_a_out = 1'h0;
        phase_b_out = 1'h0;
        pos_reg = 2'h0;
    end
    // Levels held eight cycles or more
    task automatic move(input logic a, input logic b, input int hold);
        phase_a_out <= a;
        phase_b_out <= b;
        repeat ((hold < 8) ? 8 : hold) @(posedge clock_in);
    endtask : move
    // Gray walk AB 00, 10, 11, 01 counts up; the reverse walk counts down
    task automatic quad(input logic up, input int hold);
        logic [1:0] g;
        pos_reg = up ? pos_reg + 2'h1 : pos_reg - 2'h1;
        g = pos_reg ^ {1'h0, pos_reg[1]};
        move(g[0], g[1], hold);
    endtask : quad
endmodule : pin_source

// [verif/core_timer_modes_encoder_tb_top.sv]
// Self-checking bench for the core timer modes.
// Assumes the pin source model and the bound checker.
`timescale 1ns/1ns
module core_timer_modes_encoder_tb_top;
    import core_timer_pkg::*;
    typedef struct packed {
        logic [2:0] mode;
        logic [2:0] sel;
        logic [2:0] flg;
        logic [TIMER_W-1:0] pre;
        logic [TIMER_W-1:0] exp;
    } row_t;
    // Flag field: external direction enable, direction select, walk up
    row_t rows [0:16] = '{
        '{3'h1, 3'h0, 3'h1, 16'h0100, 16'h0100}, '{3'h1, 3'h1, 3'h1, 16'h0100, 16'h0101},
        '{3'h1, 3'h2, 3'h1, 16'h0100, 16'h0101}, '{3'h1, 3'h3, 3'h1, 16'h0100, 16'h0102},
        '{3'h1, 3'h3, 3'h3, 16'h0100, 16'h00fe}, '{3'h1, 3'h1, 3'h5, 16'h0100, 16'h0101},
        '{3'h1, 3'h1, 3'h7, 16'h0100, 16'h00ff}, '{3'h1, 3'h4, 3'h1, 16'h0100, 16'h0100},
        '{3'h6, 3'h0, 3'h5, 16'h0100, 16'h0100}, '{3'h6, 3'h1, 3'h5, 16'h0100, 16'h0102},
        '{3'h6, 3'h2, 3'h5, 16'h0100, 16'h0102}, '{3'h6, 3'h3, 3'h5, 16'h0100, 16'h0104},
        '{3'h6, 3'h1, 3'h4, 16'h0100, 16'h00fe}, '{3'h6, 3'h3, 3'h4, 16'h0002, 16'hfffe},
        '{3'h6, 3'h3, 3'h5, 16'hfffe, 16'h0002}, '{3'h6, 3'h4, 3'h5, 16'h0100, 16'h0100},
        '{3'h5, 3'h3, 3'h5, 16'h0100, 16'h0100}};
    logic clock_in = 1'h0;
    logic rst_in = 1'h1;
    logic [ADDR_W-1:0] addr_in = 8'h00;
    logic [DATA_W-1:0] wdata_in = 16'h0000;
    logic wr_in = 1'h0;
    logic rd_in = 1'h0;
    logic pin_a, pin_b, toggle_latch_out, alt_out_out, count_pulse_out;
    logic [DATA_W-1:0] rdata_out;
    logic [TIMER_W-1:0] timer_value_out;
    int err_total = 0;
    int num_checks = 0;
    always #4 clock_in = ~clock_in;
    pin_source src (.clock_in(clock_in), .phase_a_out(pin_a), .phase_b_out(pin_b));
    core_timer dut (
        .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .count_gate_in(pin_a), .direction_in(pin_b),
        .rdata_out(rdata_out), .timer_value_out(timer_value_out),
        .toggle_latch_out(toggle_latch_out), .alt_out_out(alt_out_out),
        .count_down_out(), .count_pulse_out(count_pulse_out)
    );
    // ----------------
    // Helpers
    // ----------------
    function automatic logic [DATA_W-1:0] cw(input logic [2:0] m, input logic [2:0] s,
                                             input logic [1:0] f, input logic r);
        return {7'h00, f, r, m, s};
    endfunction : cw
    task automatic give_verdict();
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] want);
        num_checks++;
        if (seen !== want) begin
            err_total++;
            $display("[FAIL] %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'h1;
        @(posedge clock_in);
        wr_in <= 1'h0;
        @(posedge clock_in);
    endtask : bus_wr
    task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        addr_in <= a;
        rd_in <= 1'h1;
        @(posedge clock_in);
        rd_in <= 1'h0;
        @(negedge clock_in);
        d = rdata_out;
        @(posedge clock_in);
    endtask : bus_rd
    // Cycles until the next count pulse; a lost pulse ends the run
    task automatic wait_pulse(output int n);
        n = 0;
        do begin
            @(negedge clock_in);
            n++;
        end while (count_pulse_out !== 1'h1 && n < 2100);
        if (n >= 2100) begin
            err_total++;
            $display("[FAIL] %0t no count pulse", $time);
            give_verdict();
        end else begin
            @(posedge clock_in);
        end
    endtask : wait_pulse
    task automatic gate_try(input logic moving);
        logic [TIMER_W-1:0] t;
        repeat (8) @(posedge clock_in);
        t = timer_value_out;
        repeat (40) @(posedge clock_in);
        check(16'(timer_value_out != t), 16'(moving));
    endtask : gate_try
    // ----------------
    // Sequence
    // ----------------
    initial begin
        logic [DATA_W-1:0] v;
        int n;
        repeat (16) @(posedge clock_in);
        rst_in <= 1'h0;
        @(posedge clock_in);
        // Encoder rows set the external direction enable
        foreach (rows[i]) begin
            bus_wr(TIMER_OFFSET, rows[i].pre);
            bus_wr(CTRL_OFFSET, cw(rows[i].mode, rows[i].sel, rows[i].flg[2:1], 1'h1));
            repeat (4) src.quad(rows[i].flg[0], 8 + 4 * (i % 2));
            repeat (6) @(posedge clock_in);
            bus_wr(CTRL_OFFSET, 16'h0000);
            bus_rd(TIMER_OFFSET, v);
            check(v, rows[i].exp);
        end
        // Tick period for every select code
        for (int s = 0; s < 8; s++) begin
            bus_wr(CTRL_OFFSET, cw(MODE_TIMER, 3'(s), 2'h0, 1'h1));
            wait_pulse(n);
            wait_pulse(n);
            check(16'(n), 16'(8 << s));
        end
        src.move(1'h1, 1'h0, 8);
        bus_wr(CTRL_OFFSET, cw(MODE_GATED_LOW, 3'h0, 2'h0, 1'h1));
        gate_try(1'h0);
        src.move(1'h0, 1'h0, 8);
        gate_try(1'h1);
        bus_wr(CTRL_OFFSET, cw(MODE_GATED_LOW, 3'h0, 2'h0, 1'h0));
        gate_try(1'h0);
        bus_wr(CTRL_OFFSET, cw(MODE_GATED_HIGH, 3'h0, 2'h0, 1'h1));
        gate_try(1'h0);
        src.move(1'h1, 1'h0, 8);
        gate_try(1'h1);
        bus_wr(CTRL_OFFSET, cw(MODE_TIMER, 3'h0, 2'h0, 1'h1));
        addr_in <= TIMER_OFFSET;
        wdata_in <= 16'h1234;
        wr_in <= 1'h1;
        repeat (9) @(posedge clock_in);
        wr_in <= 1'h0;
        @(negedge clock_in);
        check(timer_value_out, 16'h1234);
        @(posedge clock_in);
        // Wrap toggles the latch, software sets and clears it
        bus_wr(TIMER_OFFSET, 16'hfffc);
        repeat (48) @(posedge clock_in);
        check(16'(toggle_latch_out), 16'h0001);
        bus_wr(CTRL_OFFSET, 16'h0200);
        check(16'(toggle_latch_out), 16'h0000);
        bus_wr(CTRL_OFFSET, 16'h0600);
        check(16'(alt_out_out), 16'h0001);
        bus_wr(8'h04, 16'hbeef);
        bus_rd(8'h04, v);
        check(v, READ_IDLE);
        bus_rd(CTRL_OFFSET, v);
        check(v, 16'h0600);
        // Reset in mid-run clears control and timer
        bus_wr(CTRL_OFFSET, cw(MODE_TIMER, 3'h0, 2'h0, 1'h1));
        repeat (40) @(posedge clock_in);
        rst_in <= 1'h1;
        repeat (16) @(posedge clock_in);
        rst_in <= 1'h0;
        @(posedge clock_in);
        bus_rd(CTRL_OFFSET, v);
        check(v, 16'h0000);
        check(timer_value_out, TIMER_RESET);
        give_verdict();
    end
endmodule : core_timer_modes_encoder_tb_top
